// file: design/amp_ctrl_pkg.sv
package amp_ctrl_pkg;

  // Register offsets on the control port
  localparam logic [7:0] REG_FRAME_CTRL = 8'h04;
  localparam logic [7:0] REG_SLOT_CTRL = 8'h05;
  localparam logic [7:0] REG_VBAT = 8'h06;
  localparam logic [7:0] REG_LIM_RATE = 8'h07;
  localparam logic [7:0] REG_LIM_THR = 8'h08;
  localparam logic [7:0] REG_KNEE = 8'h09;

  // Reset values
  localparam logic [7:0] RST_FRAME_CTRL = 8'h11;
  localparam logic [7:0] RST_SLOT_CTRL = 8'h00;
  localparam logic [7:0] RST_VBAT = 8'h00;
  localparam logic [7:0] RST_LIM_RATE = 8'ha4;
  localparam logic [7:0] RST_LIM_THR = 8'h51;
  localparam logic [7:0] RST_KNEE = 8'h22;

  // Field positions
  localparam int SLOT_WIDTH_LSB = 3;
  localparam int DATA_WIDTH_BIT = 7;
  localparam int AUTO_SLOT_BIT = 4;
  localparam int SLOT_LSB = 0;
  localparam int RECOVERY_LSB = 6;
  localparam int REDUCTION_LSB = 4;
  localparam int TRACK_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int CEILING_LSB = 3;
  localparam int SLOPE_LSB = 0;

  // Word lengths on the serial audio input
  localparam int WORD_LONG = 24;
  localparam int WORD_SHORT = 16;

  // Battery code to millivolts scale
  localparam int BAT_BASE_MV = 3800;
  localparam int BAT_SPAN_MV = 12400;
  localparam int BAT_FULL_CODE = 255;

  // Limiter or mute modes, in field code order
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_ALWAYS,
    MODE_MUTE_LOW,
    MODE_LIMIT_LOW
  } limiter_mode_e;

  // Link set-up handed to the slot capture
  typedef struct packed {
    logic word_short;
    logic [3:0] slot_index;
    logic [2:0] slot_width_clocks;
  } slot_cfg_s;

  // One captured audio word
  typedef struct packed {
    logic [23:0] data;
    logic valid;
  } audio_word_s;

endpackage : amp_ctrl_pkg

// file: design/audio_slot_limiter_regs.sv
module audio_slot_limiter_regs
  import amp_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR_BASE = 7'h28 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_pin,
  input wire logic bclk_pin,
  input wire logic fsync_pin,
  input wire logic serial_audio_input,
  input wire logic [7:0] battery_code,
  output audio_word_s audio_word,
  output logic limiter_engaged,
  output logic output_mute,
  output logic battery_low,
  output logic threshold_tracking,
  output logic [11:0] recovery_ms_per_db,
  output logic [6:0] reduction_us_per_db,
  output logic [13:0] ceiling_mv,
  output logic [13:0] effective_ceiling_mv,
  output logic [2:0] slope_ratio,
  output logic [14:0] knee_mv
);

  // Reset release
  logic rst_meta; // First reset stage
  logic rst_n; // Released reset used by all logic

  // Address pin synchroniser
  logic [1:0] addr_meta; // First stage
  logic [1:0] addr_sync; // Second stage

  // Register storage
  logic [7:0] frame_ctrl; // Frame set-up, holds slot width
  logic [7:0] serial_audio_slot_control; // Width, auto slot, slot field
  logic [7:0] battery_voltage_reading; // Sensed battery code
  logic [7:0] limiter_rate_mode_control; // Rates, tracking, mode
  logic [7:0] limiter_threshold_control; // Ceiling and slope
  logic [7:0] battery_knee_point; // Knee point code

  // Control port wires
  logic [7:0] rd_addr; // Read pointer from the port
  logic wr_en; // One-cycle write strobe
  logic [7:0] wr_addr; // Write target
  logic [7:0] wr_data; // Write value
  logic port_oe_n; // Port drive, low pulls the line

  // Audio capture
  audio_word_s captured; // Word from the slot capture
  slot_cfg_s slot_cfg; // Link set-up

  // Millivolts from an eight-bit battery code
  function automatic logic [14:0] code_to_mv(input logic [7:0] code);
    int mv;
    mv = BAT_BASE_MV + (BAT_SPAN_MV * int'(code)) / BAT_FULL_CODE;
    code_to_mv = 15'(mv);
  endfunction : code_to_mv

  // Peak output ceiling in millivolts for a five-bit code
  function automatic logic [13:0] ceiling_of(input logic [4:0] code);
    int mv;
    if (code <= 5'h0d) begin
      mv = 15000 - 500 * int'(code);
    end else if (code <= 5'h13) begin
      mv = 8250 - 250 * (int'(code) - 14);
    end else begin
      mv = 6500 - 500 * (int'(code) - 20);
    end
    ceiling_of = 14'(mv);
  endfunction : ceiling_of

  // Register write decode
  wire wr_frame = wr_en && (wr_addr == REG_FRAME_CTRL);
  wire wr_slot = wr_en && (wr_addr == REG_SLOT_CTRL);
  wire wr_rate = wr_en && (wr_addr == REG_LIM_RATE);
  wire wr_thr = wr_en && (wr_addr == REG_LIM_THR);
  wire wr_knee = wr_en && (wr_addr == REG_KNEE);

  // Register read selection, unmapped offsets read zero
  wire [7:0] rd_data =
    (rd_addr == REG_FRAME_CTRL) ? frame_ctrl :
    (rd_addr == REG_SLOT_CTRL) ? serial_audio_slot_control :
    (rd_addr == REG_VBAT) ? battery_voltage_reading :
    (rd_addr == REG_LIM_RATE) ? limiter_rate_mode_control :
    (rd_addr == REG_LIM_THR) ? limiter_threshold_control :
    (rd_addr == REG_KNEE) ? battery_knee_point : 8'h00;

  // Field extraction
  wire auto_slot = serial_audio_slot_control[AUTO_SLOT_BIT];
  wire [3:0] slot_field = serial_audio_slot_control[SLOT_LSB +: 4];
  wire [1:0] gain_recovery_rate = limiter_rate_mode_control[RECOVERY_LSB +: 2];
  wire [1:0] gain_reduction_rate = limiter_rate_mode_control[REDUCTION_LSB +: 2];
  wire tracking = limiter_rate_mode_control[TRACK_BIT];
  wire [4:0] peak_ceiling_field = limiter_threshold_control[CEILING_LSB +: 5];
  wire [1:0] slope_field = limiter_threshold_control[SLOPE_LSB +: 2];
  // Mode field as its enum
  limiter_mode_e limiter_mode_sel;
  assign limiter_mode_sel = limiter_mode_e'(limiter_rate_mode_control[MODE_LSB +: 2]);

  // Slot choice: pin when automatic, field otherwise
  wire [3:0] slot_index = auto_slot ? {2'h0, addr_sync} : slot_field;

  // Battery comparison on the shared scale
  wire [14:0] next_knee_mv = code_to_mv(battery_knee_point);
  wire [14:0] battery_mv = code_to_mv(battery_voltage_reading);
  wire below_knee = battery_voltage_reading < battery_knee_point;

  // Mode decode
  wire next_engaged = (limiter_mode_sel == MODE_ALWAYS) ||
                      ((limiter_mode_sel == MODE_LIMIT_LOW) && below_knee);
  wire next_mute = (limiter_mode_sel == MODE_MUTE_LOW) && below_knee;

  // Rate decode
  wire [11:0] next_recovery =
    (gain_recovery_rate == 2'h0) ? 12'd3200 :
    (gain_recovery_rate == 2'h1) ? 12'd1600 :
    (gain_recovery_rate == 2'h2) ? 12'd1200 : 12'd800;

  wire [6:0] next_reduction =
    (gain_reduction_rate == 2'h0) ? 7'd120 :
    (gain_reduction_rate == 2'h1) ? 7'd60 :
    (gain_reduction_rate == 2'h2) ? 7'd30 : 7'd20;

  // Tracked ceiling drops by slope times battery drop
  wire [13:0] next_ceiling = ceiling_of(peak_ceiling_field);
  wire [2:0] next_slope = {1'b0, slope_field} + 3'h1;

  wire [14:0] battery_drop = below_knee ? (next_knee_mv - battery_mv) : 15'h0000;
  wire [17:0] cut_mv = 18'(battery_drop * next_slope);
  wire [17:0] ceiling_wide = {4'h0, next_ceiling};

  wire [13:0] next_effective =
    !tracking ? next_ceiling :
    (cut_mv >= ceiling_wide) ? 14'h0000 : 14'(ceiling_wide - cut_mv);

  // Link set-up for the capture
  assign slot_cfg.word_short = serial_audio_slot_control[DATA_WIDTH_BIT];
  assign slot_cfg.slot_index = slot_index;
  assign slot_cfg.slot_width_clocks = frame_ctrl[SLOT_WIDTH_LSB +: 3];

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Address pin synchroniser
  // Pin value also feeds the port address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_meta <= 2'h0;
      addr_sync <= 2'h0;
    end else begin
      addr_meta <= addr_pin;
      addr_sync <= addr_meta;
    end
  end

  // Writable registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_ctrl <= RST_FRAME_CTRL;
      serial_audio_slot_control <= RST_SLOT_CTRL;
      limiter_rate_mode_control <= RST_LIM_RATE;
      limiter_threshold_control <= RST_LIM_THR;
      battery_knee_point <= RST_KNEE;
    end else begin
      // Each register takes the byte only on its own strobe
      if (wr_frame) begin
        frame_ctrl <= wr_data;
      end

      if (wr_slot) begin
        serial_audio_slot_control <= wr_data;
      end

      if (wr_rate) begin
        limiter_rate_mode_control <= wr_data;
      end

      if (wr_thr) begin
        limiter_threshold_control <= wr_data;
      end

      if (wr_knee) begin
        battery_knee_point <= wr_data;
      end
    end
  end

  // Battery reading follows the sensor only; port writes never reach it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      battery_voltage_reading <= RST_VBAT;
    end else begin
      battery_voltage_reading <= battery_code;
    end
  end

  // Registered limiter outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limiter_engaged <= 1'b0;
      output_mute <= 1'b0;
      battery_low <= 1'b0;
      // Tracking resets on, as its register bit does
      threshold_tracking <= 1'b1;
      recovery_ms_per_db <= 12'h000;
      reduction_us_per_db <= 7'h00;
      ceiling_mv <= 14'h0000;
      effective_ceiling_mv <= 14'h0000;
      slope_ratio <= 3'h0;
      knee_mv <= 15'h0000;
    end else begin
      // Limiter state
      limiter_engaged <= next_engaged;
      output_mute <= next_mute;
      battery_low <= below_knee;
      threshold_tracking <= tracking;
      // Rates and ceilings
      recovery_ms_per_db <= next_recovery;
      reduction_us_per_db <= next_reduction;
      ceiling_mv <= next_ceiling;
      effective_ceiling_mv <= next_effective;
      slope_ratio <= next_slope;
      knee_mv <= next_knee_mv;
    end
  end

  // Pin drive flops; the line is only ever pulled low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= port_oe_n;
    end
  end

  // Captured word, registered at the block edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      audio_word <= '0;
    end else begin
      audio_word <= captured;
    end
  end

  // Control port target, address set by the pin
  ctrl_port_target u_port (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .dev_addr(DEV_ADDR_BASE | {5'h00, addr_sync}),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .sda_oe_n(port_oe_n)
  );

  // Slot capture on the serial audio link
  slot_capture u_capture (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bclk_pin(bclk_pin),
    .fsync_pin(fsync_pin),
    .serial_audio_input(serial_audio_input),
    .cfg(slot_cfg),
    .word_out(captured)
  );

endmodule : audio_slot_limiter_regs

// file: design/ctrl_port_target.sv
// Two-wire control port target with pointer auto-increment
module ctrl_port_target
  import amp_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] rd_data,
  output logic [7:0] rd_addr,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic sda_oe_n
);

  typedef enum logic [3:0] {
    IDLE, ADDR, ACK_ADDR, PTR, ACK_PTR, WDATA, ACK_WDATA, RDATA, ACK_RDATA
  } port_state_e;

  port_state_e state;
  logic [1:0] scl_sync; // Two-stage pin synchronisers
  logic [1:0] sda_sync;
  logic scl_prev; // Previous synchronised levels
  logic sda_prev;
  logic [7:0] shift; // Received byte
  logic [7:0] tx; // Byte being sent
  logic [3:0] cnt; // Bits seen in this byte
  logic rw; // Read requested
  logic nack; // Master refused the last read byte

  // Bus conditions from synchronised levels
  wire scl_rise = scl_sync[1] & ~scl_prev;
  wire scl_fall = ~scl_sync[1] & scl_prev;
  wire start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  wire stop_seen = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  wire byte_done = (cnt == 4'h8);
  wire rx_phase = (state == ADDR) | (state == PTR) | (state == WDATA);

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Byte engine; data changes only while the clock is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      nack <= 1'b0;
      rd_addr <= 8'h00;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      sda_oe_n <= 1'b1;
    end else begin
      wr_en <= 1'b0;
      if (start_seen) begin
        state <= ADDR;
        cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        state <= IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (rx_phase) begin
          shift <= {shift[6:0], sda_sync[1]};
        end
        if (state == ACK_RDATA) begin
          nack <= sda_sync[1];
        end
        cnt <= cnt + 4'h1;
      end else if (scl_fall) begin
        unique case (state)
          IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ADDR: begin
            if (byte_done && shift[7:1] == dev_addr) begin
              rw <= shift[0];
              state <= ACK_ADDR;
              sda_oe_n <= 1'b0;
            end else if (byte_done) begin
              state <= IDLE;
            end
          end
          ACK_ADDR: begin
            cnt <= 4'h0;
            if (rw) begin
              state <= RDATA;
              tx <= rd_data;
              sda_oe_n <= rd_data[7];
            end else begin
              state <= PTR;
              sda_oe_n <= 1'b1;
            end
          end
          PTR: begin
            if (byte_done) begin
              rd_addr <= shift;
              state <= ACK_PTR;
              sda_oe_n <= 1'b0;
            end
          end
          WDATA: begin
            if (byte_done) begin
              wr_en <= 1'b1;
              wr_addr <= rd_addr;
              wr_data <= shift;
              state <= ACK_WDATA;
              sda_oe_n <= 1'b0;
            end
          end
          ACK_PTR, ACK_WDATA: begin
            if (state == ACK_WDATA) begin
              rd_addr <= rd_addr + 8'h01;
            end
            cnt <= 4'h0;
            state <= WDATA;
            sda_oe_n <= 1'b1;
          end
          RDATA: begin
            if (byte_done) begin
              rd_addr <= rd_addr + 8'h01;
              state <= ACK_RDATA;
              sda_oe_n <= 1'b1;
            end else begin
              tx <= {tx[6:0], 1'b0};
              sda_oe_n <= tx[6];
            end
          end
          ACK_RDATA: begin
            cnt <= 4'h0;
            if (nack) begin
              state <= IDLE;
            end else begin
              state <= RDATA;
              tx <= rd_data;
              sda_oe_n <= rd_data[7];
            end
          end
        endcase
      end
    end
  end

endmodule : ctrl_port_target

// file: design/slot_capture.sv
// Time-division slot capture of one audio word per frame
module slot_capture
  import amp_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bclk_pin,
  input wire logic fsync_pin,
  input wire logic serial_audio_input,
  input wire slot_cfg_s cfg,
  output audio_word_s word_out
);

  logic [2:0] bclk_sync; // Two sync stages plus edge history
  logic [1:0] fsync_sync;
  logic [1:0] data_sync;
  logic fsync_last; // Frame sync as seen at the previous bit clock
  logic [10:0] pos; // Bit position of the next bit in the frame
  logic [23:0] shift; // Bits of the selected slot

  // Slot width in bit clocks, unused codes read as the widest
  function automatic logic [10:0] width_clocks(input logic [2:0] code);
    unique case (code)
      3'h0: width_clocks = 11'h010;
      3'h1: width_clocks = 11'h018;
      3'h2: width_clocks = 11'h020;
      3'h3: width_clocks = 11'h030;
      default: width_clocks = 11'h040;
    endcase
  endfunction : width_clocks

  wire bclk_rise = bclk_sync[1] & ~bclk_sync[2];
  wire frame_start = fsync_sync[1] & ~fsync_last;
  wire [10:0] here = frame_start ? 11'h000 : pos;
  // Slot n starts n widths into the frame
  wire [10:0] offset = 11'({7'h00, cfg.slot_index} * width_clocks(cfg.slot_width_clocks));
  wire [10:0] word_len = cfg.word_short ? 11'(WORD_SHORT) : 11'(WORD_LONG);
  wire in_word = (here >= offset) && (here < offset + word_len);
  wire last_bit = (here == offset + word_len - 11'h001);
  wire [23:0] next_shift = {shift[22:0], data_sync[1]};

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bclk_sync <= 3'h0;
      fsync_sync <= 2'h0;
      data_sync <= 2'h0;
    end else begin
      bclk_sync <= {bclk_sync[1:0], bclk_pin};
      fsync_sync <= {fsync_sync[0], fsync_pin};
      data_sync <= {data_sync[0], serial_audio_input};
    end
  end

  // Bit counting and word assembly on the bit clock rising edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fsync_last <= 1'b0;
      pos <= 11'h7ff;
      shift <= 24'h000000;
      word_out <= '0;
    end else begin
      word_out.valid <= 1'b0;
      if (bclk_rise) begin
        fsync_last <= fsync_sync[1];
        pos <= (here == 11'h7ff) ? here : here + 11'h001;
        if (in_word) begin
          shift <= next_shift;
        end
        if (in_word && last_bit) begin
          // Short words sit in the upper bits
          word_out.data <= cfg.word_short ? {next_shift[15:0], 8'h00} : next_shift;
          word_out.valid <= 1'b1;
        end
      end
    end
  end

endmodule : slot_capture

// file: verif/audio_slot_limiter_regs_bench.sv
module audio_slot_limiter_regs_bench
  import amp_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, nrst = 1'b0, scl_pin, sda_pin, sda_out, sda_oe_n, bclk_pin;
  logic fsync_pin, serial_audio_input, limiter_engaged, output_mute, battery_low;
  logic threshold_tracking, nak;
  logic [1:0] addr_pin = 2'd0;
  logic [7:0] battery_code = 8'h00, rd;
  logic [11:0] recovery_ms_per_db;
  logic [6:0] reduction_us_per_db, dev = 7'h28;
  logic [13:0] ceiling_mv, effective_ceiling_mv;
  logic [2:0] slope_ratio;
  logic [14:0] knee_mv;
  logic [23:0] got, w;
  audio_word_s audio_word;
  int fails = 0, n_tests = 0, n_words = 0, n0, k;
  typedef struct packed {
    logic [7:0] rate, thr, bat;
    logic [11:0] rec;
    logic [6:0] red;
    logic eng, mute;
    logic [13:0] ceil, eff;
    logic [2:0] slope;
  } row_s;
  // Registers, battery code, expected outputs
  row_s rows [9] = '{'{8'h00, 8'h00, 8'h00, 3200, 120, 0, 0, 15000, 15000, 1},
    '{8'h51, 8'h69, 8'h80, 1600, 60, 1, 0, 8500, 8500, 2},
    '{8'ha2, 8'h72, 8'h00, 1200, 30, 0, 1, 8250, 8250, 3},
    '{8'hf3, 8'h9b, 8'h00, 800, 20, 1, 0, 7000, 7000, 4},
    '{8'h13, 8'ha0, 8'h80, 3200, 60, 0, 0, 6500, 6500, 1},
    '{8'h82, 8'hf9, 8'h80, 1200, 120, 0, 0, 1000, 1000, 2},
    '{8'ha4, 8'h51, 8'h00, 1200, 30, 0, 0, 10000, 6694, 2},
    '{8'ha7, 8'h51, 8'h22, 1200, 30, 0, 0, 10000, 10000, 2},
    '{8'ha4, 8'hfb, 8'h00, 1200, 30, 0, 0, 1000, 0, 4}};
  typedef struct packed {
    logic [7:0] fr, sl;
    logic [1:0] ap;
    logic [9:0] off;
    logic [4:0] len;
  } tdm_s;
  // Frame and slot set-up, pin, word offset and length
  tdm_s cases [5] = '{'{8'h11, 8'h00, 0, 0, 24}, '{8'h01, 8'h8f, 0, 240, 16},
    '{8'h19, 8'h83, 0, 144, 16}, '{8'h09, 8'h05, 0, 120, 24}, '{8'h21, 8'h12, 3, 192, 24}};
  logic [7:0] rst_tab [4] = '{8'h00, 8'h00, 8'ha4, 8'h51}; // Offsets 0x05 to 0x08
  audio_slot_limiter_regs dut_u (.*);
  link_partner_model host_u (.*);
  always #25 clk_sys = ~clk_sys;
  // Capture each delivered word
  always @(posedge clk_sys) begin
    if (audio_word.valid === 1'b1) begin
      got = audio_word.data;
      n_words++;
    end
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    final_report;
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    host_u.tick(6);
    foreach (rows[i]) begin
      host_u.acc(1'b0, dev, REG_LIM_RATE, rows[i].rate, rd, nak);
      host_u.acc(1'b0, dev, REG_LIM_THR, rows[i].thr, rd, nak);
      battery_code = rows[i].bat;
      host_u.acc(1'b1, dev, REG_LIM_RATE, '0, rd, nak);
      check("rate reg", rd, rows[i].rate);
      check("recovery", recovery_ms_per_db, rows[i].rec);
      check("reduction", reduction_us_per_db, rows[i].red);
      check("tracking", threshold_tracking, rows[i].rate[2]);
      check("engaged", limiter_engaged, rows[i].eng);
      check("mute", output_mute, rows[i].mute);
      check("low", battery_low, rows[i].bat < RST_KNEE);
      check("ceiling", ceiling_mv, rows[i].ceil);
      check("slope", slope_ratio, rows[i].slope);
      check("effective", effective_ceiling_mv, rows[i].eff);
    end
    foreach (cases[i]) begin
      addr_pin = cases[i].ap;
      dev = 7'h28 | 7'(cases[i].ap);
      host_u.tick(4);
      host_u.acc(1'b0, dev, REG_FRAME_CTRL, cases[i].fr, rd, nak);
      host_u.acc(1'b0, dev, REG_SLOT_CTRL, cases[i].sl, rd, nak);
      check("ack", nak, 1'b0);
      n0 = n_words;
      w = 24'hc35a96 ^ 24'(i);
      host_u.frame(int'(cases[i].off), int'(cases[i].len), w);
      for (k = 0; n_words == n0 && k < 40; k++) begin
        @(negedge clk_sys);
      end
      if (n_words == n0) begin
        fails++;
        final_report;
      end
      check("word count", 24'(n_words - n0), 24'd1);
      check("word", got, cases[i].len == 16 ? {w[23:8], 8'h00} : w);
    end
    host_u.acc(1'b0, 7'h28, REG_LIM_RATE, 8'h00, rd, nak);
    check("foreign address", nak, 1'b1);
    battery_code = 8'h3c;
    host_u.acc(1'b0, dev, REG_VBAT, 8'hff, rd, nak);
    host_u.acc(1'b1, dev, REG_VBAT, '0, rd, nak);
    check("battery reg", rd, 8'h3c);
    host_u.acc(1'b1, dev, 8'h30, '0, rd, nak);
    check("unmapped", rd, 8'h00);
    // Second reset in mid-run
    battery_code = 8'h00;
    nrst = 1'b0;
    host_u.tick(2);
    nrst = 1'b1;
    host_u.tick(6);
    check("reset recovery", recovery_ms_per_db, 12'd1200);
    check("reset tracking", threshold_tracking, 1'b1);
    check("reset slope", slope_ratio, 3'd2);
    check("knee", knee_mv, 15'd5453);
    foreach (rst_tab[i]) begin
      host_u.acc(1'b1, dev, REG_SLOT_CTRL + 8'(i), '0, rd, nak);
      check("reset reg", rd, rst_tab[i]);
    end
    final_report;
  end
endmodule : audio_slot_limiter_regs_bench

// file: verif/link_partner_model.sv
module link_partner_model (
  input wire logic clk_sys,
  input wire logic sda_oe_n,
  output logic scl_pin = 1'b1,
  output logic sda_pin,
  output logic bclk_pin = 1'b0,
  output logic fsync_pin = 1'b0,
  output logic serial_audio_input = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_host = 1'b1; // Host side, 1 = released
  // Pulled-up wire: low when either side pulls
  assign sda_pin = sda_host & sda_oe_n;
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // Data set in clock low, sampled late in clock high
  task automatic put_bit(input logic b, output logic seen);
    tick(4);
    sda_host = b;
    tick(4);
    scl_pin = 1'b1;
    tick(8);
    seen = sda_pin;
    scl_pin = 1'b0;
  endtask : put_bit
  // Start, also used as repeated start
  task automatic start;
    sda_host = 1'b1;
    tick(8);
    scl_pin = 1'b1;
    tick(8);
    sda_host = 1'b0;
    tick(8);
    scl_pin = 1'b0;
  endtask : start
  task automatic stop;
    tick(4);
    sda_host = 1'b0;
    tick(8);
    scl_pin = 1'b1;
    tick(8);
    sda_host = 1'b1;
    tick(8);
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(ack_in, ack);
  endtask : xfer
  // Pointer write, then one byte written, or read after a repeated start
  task automatic acc(input logic rd, input logic [6:0] dev, input logic [7:0] ptr,
                     input logic [7:0] wd, output logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start;
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    if (rd) begin
      start;
      xfer({dev, 1'b1}, 1'b1, rx, a2);
    end
    xfer(rd ? 8'hff : wd, 1'b1, d, a3);
    stop;
    nak = a0 | a1 | (rd ? a2 : a3);
  endtask : acc
  // Frame: sync at 0, word MSB first at off
  task automatic frame(input int off, input int len, input logic [23:0] w);
    for (int p = 0; p < off + len + 2; p++) begin
      fsync_pin = (p == 0);
      serial_audio_input = (p >= off && p < off + len) ? w[23 - (p - off)] : p[0];
      tick(4);
      bclk_pin = 1'b1;
      tick(4);
      bclk_pin = 1'b0;
    end
    serial_audio_input = ~serial_audio_input;
  endtask : frame
endmodule : link_partner_model

// file: verif/slot_limiter_checker.sv
module slot_limiter_checker
  import amp_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] battery_code,
  input wire audio_word_s audio_word,
  input wire logic limiter_engaged,
  input wire logic output_mute,
  input wire logic battery_low,
  input wire logic threshold_tracking,
  input wire logic [11:0] recovery_ms_per_db,
  input wire logic [6:0] reduction_us_per_db,
  input wire logic [13:0] ceiling_mv,
  input wire logic [13:0] effective_ceiling_mv,
  input wire logic [2:0] slope_ratio,
  input wire logic [14:0] knee_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [2:0] up_cnt; // Edges since release
  wire live = up_cnt == 3'd4; // Internal reset is over
  wire [15:0] bat_mv = 16'(BAT_BASE_MV + BAT_SPAN_MV * battery_code / BAT_FULL_CODE);
  // Count edges after release, stop at four
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_cnt <= 3'd0;
    end else if (!live) begin
      up_cnt <= up_cnt + 3'd1;
    end
  end
  property p_mute_low; output_mute |-> battery_low; endproperty
  a_mute_low: assert property (p_mute_low) else $error("mute, battery high");
  property p_mute_excl; output_mute |-> !limiter_engaged; endproperty
  a_mute_excl: assert property (p_mute_excl) else $error("mute and limit");
  property p_low_knee;
    ($stable(battery_code) && $stable(knee_mv)) [*5] |-> battery_low == (bat_mv < knee_mv);
  endproperty
  a_low_knee: assert property (p_low_knee) else $error("low flag wrong");
  property p_rec; live |-> recovery_ms_per_db inside {3200, 1600, 1200, 800}; endproperty
  a_rec: assert property (p_rec) else $error("bad recovery");
  property p_red; live |-> reduction_us_per_db inside {120, 60, 30, 20}; endproperty
  a_red: assert property (p_red) else $error("bad reduction");
  property p_slope; live |-> slope_ratio inside {[1:4]}; endproperty
  a_slope: assert property (p_slope) else $error("bad slope");
  property p_ceil;
    live |-> ceiling_mv inside {[1000:15000]} &&
      ceiling_mv % (ceiling_mv inside {[7250:8250]} ? 250 : 500) == 0;
  endproperty
  a_ceil: assert property (p_ceil) else $error("ceiling off table");
  property p_fixed;
    live && !threshold_tracking && $stable(threshold_tracking) && $stable(ceiling_mv)
      |-> effective_ceiling_mv == ceiling_mv;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed ceiling moved");
  property p_word; audio_word.valid |=> (!audio_word.valid) [*8]; endproperty
  a_word: assert property (p_word) else $error("word too soon");
  c_mute: cover property (output_mute);
  c_limit: cover property (limiter_engaged && battery_low);
  c_word: cover property (audio_word.valid);
endmodule : slot_limiter_checker

bind audio_slot_limiter_regs slot_limiter_checker chk_u (.*);
